// file: core/nv_ctrl_pkg.sv
// Purpose: Shared constants and types for the byte-wide non-volatile memory controller
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Offsets and field positions are used through nv_ctrl_pkg::name only
package nv_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_LOCATION = 8'h00;
    localparam logic [7:0] OFF_BYTE     = 8'h04;
    localparam logic [7:0] OFF_CONTROL  = 8'h08;
    localparam logic [7:0] OFF_BANK     = 8'h0c;
    localparam logic [7:0] OFF_IRQ      = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_RD_TRIG  = 0;
    localparam int CTL_RD_PERM  = 1;
    localparam int CTL_WR_TRIG  = 2;
    localparam int CTL_WR_PERM  = 3;
    localparam int IRQ_GLOBAL   = 0;
    localparam int IRQ_NV_EN    = 1;
    localparam int IRQ_MF_EN    = 2;
    localparam int IRQ_NV_FLAG  = 3;
    localparam int IRQ_MF_FLAG  = 4;
    localparam int BANK_CONTROL = 1;

    // ------------------------------------------------------------
    // Sizes, reset values and timing
    // ------------------------------------------------------------
    localparam int         LOC_W      = 6;
    localparam int         DEPTH      = 64;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [3:0] RST_CTL    = 4'h0;
    localparam int         RD_CYCLES  = 2;
    localparam int         WR_TIME_NS = 2000;
    localparam int         CLK_NS     = 10;
    localparam int         WR_CYCLES  = WR_TIME_NS / CLK_NS;
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Memory access states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } nv_state_e;

    // Control register fields
    typedef struct packed {
        logic writePermit;
        logic writeTrig;
        logic readPermit;
        logic readTrig;
    } nv_ctrl_s;

endpackage : nv_ctrl_pkg

// file: core/nv_byte_ctrl.sv
// Purpose: Byte read/write controller for a 64x8 non-volatile data memory
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes:   Write duration comes from an internal down-counter loaded at write start, not the bus
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// Summary of operation
// (R1) Read trigger ignored unless read permit already set.
// (R2) Read trigger self-clears when read ends; byte then in data register.
// (R3) Data register keeps read byte until next read or write.
// (R4) Software loads location and byte, then permit, then write trigger.
// (R5) Software sets write permit and trigger back to back.
// (R6) Software masks global interrupt around write start.
// (R7) Write trigger with write permit low starts no write.
// (R8) Write length timed by internal timer, nonzero delay.
// (R9) Write trigger self-clears at end of write.
// (R10) Write permit cleared at reset.
// (R11) Bank pointer resets to zero, hiding the control register.
// (R12) Write end sets memory flag and multi-function flag.
// (R13) Vector request only with all three enables and stack not full.
// (R14) Service clears multi-function flag only; memory flag cleared by software.
// (R15) Software avoids sleep while an access is pending.
// (R16) Software keeps write permit low when idle.
// (R17) Software polls write trigger or uses interrupt.
// (R18) Software never sets both triggers together.
// (R19) Memory is 64 bytes, six-bit location field.
// (R20) Control bits: 3 write permit, 2 write trigger, 1 read permit, 0 read trigger.
// (R21) Read byte loaded no later than trigger clear.
module nv_byte_ctrl (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // CPU interrupt handshake
    input  wire logic        stackFull,
    input  wire logic        irqService,
    output logic             irqVector
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]                 mem [nv_ctrl_pkg::DEPTH];
    logic [nv_ctrl_pkg::LOC_W-1:0] locR, locNxt;
    logic [7:0]                 byteR, byteNxt;
    nv_ctrl_pkg::nv_ctrl_s      ctlR, ctlNxt;
    logic                       bankR, bankNxt;
    logic [2:0]                 enR, enNxt;
    logic                       nvFlagR, nvFlagNxt;
    logic                       mfFlagR, mfFlagNxt;
    logic                       vecR, vecNxt;
    nv_ctrl_pkg::nv_state_e     stR, stNxt;
    logic [7:0]                 cntR, cntNxt;
    logic [nv_ctrl_pkg::LOC_W-1:0] opLocR, opLocNxt;
    logic [7:0]                 opByteR, opByteNxt;
    logic                       memWe;
    logic                       awHeldR, awHeldNxt, wHeldR, wHeldNxt;
    logic [7:0]                 awAddrR, awAddrNxt;
    logic [31:0]                wDataR, wDataNxt;
    logic                       wStrbR, wStrbNxt;
    logic                       bValidR, bValidNxt, rValidR, rValidNxt;
    logic [1:0]                 bRespR, bRespNxt, rRespR, rRespNxt;
    logic [31:0]                rDataR, rDataNxt;
    logic                       doWrite, wrHit, wrCtl;
    logic [7:0]                 wAddr;
    logic [31:0]                wData;
    logic                       wLow;
    logic                       awRdyR, awRdyNxt, wRdyR, wRdyNxt, arRdyR, arRdyNxt;

    // Bus handshake outputs, ready flags registered so no output is combinational
    assign s_axi_awready = awRdyR;
    assign s_axi_wready  = wRdyR;
    assign s_axi_arready = arRdyR;
    assign s_axi_bvalid  = bValidR;
    assign s_axi_bresp   = bRespR;
    assign s_axi_rvalid  = rValidR;
    assign s_axi_rresp   = rRespR;
    assign s_axi_rdata   = rDataR;
    assign irqVector     = vecR;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic       rdStart;
        logic       wrStart;
        logic       wrDone;
        logic [7:0] ra;
        rdStart   = 1'b0;
        wrStart   = 1'b0;
        wrDone    = 1'b0;
        ra        = s_axi_araddr;
        locNxt    = locR;
        byteNxt   = byteR;
        ctlNxt    = ctlR;
        bankNxt   = bankR;
        enNxt     = enR;
        nvFlagNxt = nvFlagR;
        mfFlagNxt = mfFlagR;
        stNxt     = stR;
        cntNxt    = cntR;
        opLocNxt  = opLocR;
        opByteNxt = opByteR;
        memWe     = 1'b0;
        awHeldNxt = awHeldR || (s_axi_awvalid && s_axi_awready);
        wHeldNxt  = wHeldR || (s_axi_wvalid && s_axi_wready);
        awAddrNxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddrR;
        wDataNxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wDataR;
        wStrbNxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wStrbR;
        bValidNxt = bValidR && !s_axi_bready;
        bRespNxt  = bRespR;
        rValidNxt = rValidR && !s_axi_rready;
        rRespNxt  = rRespR;
        rDataNxt  = rDataR;
        wAddr     = awHeldR ? awAddrR : s_axi_awaddr;
        wData     = wHeldR ? wDataR : s_axi_wdata;
        wLow      = wHeldR ? wStrbR : s_axi_wstrb[0];
        doWrite   = (awHeldR || (s_axi_awvalid && s_axi_awready))
                    && (wHeldR || (s_axi_wvalid && s_axi_wready)) && !bValidR;
        wrHit     = 1'b1;
        wrCtl     = 1'b0;
        // Register writes; control only visible with bank pointer on bank 1
        if (doWrite) begin
            awHeldNxt = 1'b0;
            wHeldNxt  = 1'b0;
            bValidNxt = 1'b1;
            unique case (wAddr)
                nv_ctrl_pkg::OFF_LOCATION: begin
                    if (wLow) locNxt = wData[nv_ctrl_pkg::LOC_W-1:0];
                end
                nv_ctrl_pkg::OFF_BYTE: begin
                    if (wLow) byteNxt = wData[7:0];
                end
                nv_ctrl_pkg::OFF_CONTROL: begin
                    // (R11) bank gate
                    wrHit = bankR == nv_ctrl_pkg::BANK_CONTROL[0];
                    wrCtl = wrHit && wLow;
                end
                nv_ctrl_pkg::OFF_BANK: begin
                    if (wLow) bankNxt = wData[0];
                end
                nv_ctrl_pkg::OFF_IRQ: begin
                    if (wLow) begin
                        enNxt = wData[nv_ctrl_pkg::IRQ_MF_EN:nv_ctrl_pkg::IRQ_GLOBAL];
                        // Software may only clear the memory and multi-function flags
                        if (!wData[nv_ctrl_pkg::IRQ_NV_FLAG]) nvFlagNxt = 1'b0;
                        if (!wData[nv_ctrl_pkg::IRQ_MF_FLAG]) mfFlagNxt = 1'b0;
                    end
                end
                default: wrHit = 1'b0;
            endcase
            bRespNxt = wrHit ? nv_ctrl_pkg::RESP_OKAY : nv_ctrl_pkg::RESP_SLVERR;
        end
        // Control write: permits take new value, triggers only start when idle
        if (wrCtl) begin
            ctlNxt.writePermit = wData[nv_ctrl_pkg::CTL_WR_PERM];
            ctlNxt.readPermit  = wData[nv_ctrl_pkg::CTL_RD_PERM];
            if (stR == nv_ctrl_pkg::ST_IDLE) begin
                // (R7) write needs permit
                wrStart = wData[nv_ctrl_pkg::CTL_WR_TRIG] && ctlR.writePermit;
                // (R1) read needs permit
                rdStart = wData[nv_ctrl_pkg::CTL_RD_TRIG] && ctlR.readPermit && !wrStart;
            end
        end
        // Access sequencer
        unique case (stR)
            nv_ctrl_pkg::ST_IDLE: begin
                if (wrStart) begin
                    ctlNxt.writeTrig = 1'b1;
                    opLocNxt  = locR;
                    opByteNxt = byteR;
                    // (R8) internal write timer
                    cntNxt    = 8'(nv_ctrl_pkg::WR_CYCLES - 1);
                    stNxt     = nv_ctrl_pkg::ST_WRITE;
                end else if (rdStart) begin
                    ctlNxt.readTrig = 1'b1;
                    opLocNxt = locR;
                    cntNxt   = 8'(nv_ctrl_pkg::RD_CYCLES - 1);
                    stNxt    = nv_ctrl_pkg::ST_READ;
                end
            end
            nv_ctrl_pkg::ST_READ: begin
                cntNxt = cntR - 8'h01;
                if (cntR == 8'h00) begin
                    // (R2) (R21) load byte, clear trigger
                    byteNxt         = mem[opLocR];
                    ctlNxt.readTrig = 1'b0;
                    stNxt           = nv_ctrl_pkg::ST_IDLE;
                end
            end
            nv_ctrl_pkg::ST_WRITE: begin
                cntNxt = cntR - 8'h01;
                if (cntR == 8'h00) begin
                    // (R9) clear trigger, store byte
                    memWe            = 1'b1;
                    ctlNxt.writeTrig = 1'b0;
                    wrDone           = 1'b1;
                    stNxt            = nv_ctrl_pkg::ST_IDLE;
                end
            end
            default: stNxt = nv_ctrl_pkg::ST_IDLE;
        endcase
        // (R14) service clears only multi-function flag
        if (irqService) mfFlagNxt = 1'b0;
        // (R12) both flags set; set wins over clear
        if (wrDone) begin
            nvFlagNxt = 1'b1;
            mfFlagNxt = 1'b1;
        end
        // Register reads
        if (s_axi_arvalid && s_axi_arready) begin
            rValidNxt = 1'b1;
            rRespNxt  = nv_ctrl_pkg::RESP_OKAY;
            unique case (ra)
                nv_ctrl_pkg::OFF_LOCATION: rDataNxt = {26'h0, locR};
                nv_ctrl_pkg::OFF_BYTE:     rDataNxt = {24'h0, byteR};
                nv_ctrl_pkg::OFF_CONTROL: begin
                    if (bankR == nv_ctrl_pkg::BANK_CONTROL[0]) begin
                        rDataNxt = {28'h0, ctlR};
                    end else begin
                        rDataNxt = 32'h0;
                        rRespNxt = nv_ctrl_pkg::RESP_SLVERR;
                    end
                end
                nv_ctrl_pkg::OFF_BANK:     rDataNxt = {31'h0, bankR};
                nv_ctrl_pkg::OFF_IRQ:      rDataNxt = {27'h0, mfFlagR, nvFlagR, enR};
                default: begin
                    rDataNxt = 32'h0;
                    rRespNxt = nv_ctrl_pkg::RESP_SLVERR;
                end
            endcase
        end
        // (R13) vector only with all enables and room on stack
        vecNxt = mfFlagNxt && nvFlagNxt && (&enNxt) && !stackFull;
        // Ready follows the held beats and pending responses of the next cycle
        awRdyNxt = !awHeldNxt && !bValidNxt;
        wRdyNxt  = !wHeldNxt && !bValidNxt;
        arRdyNxt = !rValidNxt;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            locR    <= '0;
            byteR   <= nv_ctrl_pkg::RST_BYTE;
            // (R10) permits and triggers cleared
            ctlR    <= nv_ctrl_pkg::RST_CTL;
            // (R11) bank pointer to zero
            bankR   <= 1'b0;
            enR     <= 3'h0;
            nvFlagR <= 1'b0;
            mfFlagR <= 1'b0;
            vecR    <= 1'b0;
            stR     <= nv_ctrl_pkg::ST_IDLE;
            cntR    <= 8'h00;
            opLocR  <= '0;
            opByteR <= 8'h00;
            awHeldR <= 1'b0;
            wHeldR  <= 1'b0;
            awAddrR <= 8'h00;
            wDataR  <= 32'h0;
            wStrbR  <= 1'b0;
            bValidR <= 1'b0;
            bRespR  <= 2'h0;
            rValidR <= 1'b0;
            rRespR  <= 2'h0;
            rDataR  <= 32'h0;
            awRdyR  <= 1'b1;
            wRdyR   <= 1'b1;
            arRdyR  <= 1'b1;
        end else begin
            locR    <= locNxt;
            byteR   <= byteNxt;
            ctlR    <= ctlNxt;
            bankR   <= bankNxt;
            enR     <= enNxt;
            nvFlagR <= nvFlagNxt;
            mfFlagR <= mfFlagNxt;
            vecR    <= vecNxt;
            stR     <= stNxt;
            cntR    <= cntNxt;
            opLocR  <= opLocNxt;
            opByteR <= opByteNxt;
            awHeldR <= awHeldNxt;
            wHeldR  <= wHeldNxt;
            awAddrR <= awAddrNxt;
            wDataR  <= wDataNxt;
            wStrbR  <= wStrbNxt;
            bValidR <= bValidNxt;
            bRespR  <= bRespNxt;
            rValidR <= rValidNxt;
            rRespR  <= rRespNxt;
            rDataR  <= rDataNxt;
            awRdyR  <= awRdyNxt;
            wRdyR   <= wRdyNxt;
            arRdyR  <= arRdyNxt;
        end
    end

    // (R19) 64x8 storage, no reset: contents are non-volatile
    always_ff @(posedge core_clk) begin
        if (memWe) mem[opLocR] <= opByteR;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RD_NEEDS_PERMIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ctlR.readTrig) |-> $past(ctlR.readPermit)) // (R1)
        else $error("read started without permit");
    AST_RD_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ctlR.readTrig) |-> ##2 !ctlR.readTrig) // (R2)
        else $error("read trigger did not clear in time");
    AST_BYTE_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stR != nv_ctrl_pkg::ST_IDLE) && !doWrite && $past(stR) == stR
        && stR == nv_ctrl_pkg::ST_WRITE |-> $stable(byteR)) // (R3)
        else $error("data byte changed during write");
    AST_WR_NEEDS_PERMIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ctlR.writeTrig) |-> $past(ctlR.writePermit)) // (R7)
        else $error("write started without permit");
    AST_WR_NONZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ctlR.writeTrig) |-> ctlR.writeTrig [*8]) // (R8)
        else $error("write ended too soon");
    AST_WR_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ctlR.writeTrig) |-> ##[1:300] !ctlR.writeTrig) // (R9)
        else $error("write trigger never cleared");
    AST_RESET_CLEAR: assert property (@(posedge core_clk)
        $past(!rst_n) && rst_n |-> ctlR == nv_ctrl_pkg::RST_CTL && !bankR) // (R10)
        else $error("control or bank not cleared by reset");
    AST_FLAGS_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(ctlR.writeTrig) |-> nvFlagR && mfFlagR) // (R12)
        else $error("write end flags missing");
    AST_VECTOR_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        vecR |-> (&enR) && mfFlagR && !$past(stackFull)) // (R13)
        else $error("vector without enables");
    AST_SERVICE_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_n)
        irqService && nvFlagR && !doWrite |=> nvFlagR) // (R14)
        else $error("service cleared memory flag");
    AST_READ_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(ctlR.readTrig) |-> byteR == mem[opLocR]) // (R21)
        else $error("read byte not loaded");

    COV_READ:  cover property (@(posedge core_clk) $fell(ctlR.readTrig));
    COV_WRITE: cover property (@(posedge core_clk) $fell(ctlR.writeTrig));
    COV_VEC:   cover property (@(posedge core_clk) $rose(vecR));

endmodule : nv_byte_ctrl

// file: tb/nv_byte_ctrl_tb_top.sv
// Purpose: Self-checking bench for the non-volatile byte controller
// Assumes: AXI4-Lite register access, 100 MHz clock, fixed stimulus only
// Notes:   Memory contents are unknown after reset, so every read follows a write
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin \
    checks++; \
    if ((gt) !== (ex)) begin \
        fails++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); \
    end \
end

module nv_byte_ctrl_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int TIMEOUT = 20000;
    logic        core_clk      = 1'b0;
    logic        rst_n         = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h1;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    logic        stackFull     = 1'b0;
    logic        irqService    = 1'b0;
    logic        irqVector;
    int          fails         = 0;
    int          checks        = 0;
    int          cycleCount    = 0;

    always #5 core_clk = ~core_clk;

    nv_byte_ctrl nv_byte_ctrl_i (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .stackFull(stackFull),
        .irqService(irqService), .irqVector(irqVector)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // Ready is looked at on the falling edge, where it is settled for the next rise
    task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data,
                            output logic [1:0] resp);
        int   n;
        logic awHit;
        logic wHit;
        logic bHit;
        @(posedge core_clk);
        s_axi_awaddr  <= addr;
        s_axi_wdata   <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        n    = 0;
        bHit = 1'b0;
        resp = 2'bxx;
        while (!bHit && n < 1000) begin
            @(negedge core_clk);
            awHit = s_axi_awvalid && s_axi_awready;
            wHit  = s_axi_wvalid && s_axi_wready;
            bHit  = s_axi_bvalid;
            if (bHit) resp = s_axi_bresp;
            @(posedge core_clk);
            if (awHit) s_axi_awvalid <= 1'b0;
            if (wHit) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] addr, output logic [31:0] data,
                           output logic [1:0] resp);
        int   n;
        logic arHit;
        logic rHit;
        @(posedge core_clk);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        n    = 0;
        rHit = 1'b0;
        data = 32'hx;
        resp = 2'bxx;
        while (!rHit && n < 1000) begin
            @(negedge core_clk);
            arHit = s_axi_arvalid && s_axi_arready;
            rHit  = s_axi_rvalid;
            if (rHit) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
            end
            @(posedge core_clk);
            if (arHit) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
    endtask : axiRead

    // Register helpers that also judge the response code
    task automatic wrOk(input logic [7:0] addr, input logic [31:0] data);
        logic [1:0] r;
        axiWrite(addr, data, r);
        `CHK("write resp", nv_ctrl_pkg::RESP_OKAY, r)
    endtask : wrOk

    task automatic rdChk(input string nm, input logic [7:0] addr, input logic [31:0] ex);
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(addr, d, r);
        `CHK("read resp", nv_ctrl_pkg::RESP_OKAY, r)
        `CHK(nm, ex, d)
    endtask : rdChk

    // Poll a control bit until it drops; bounded so a stuck bit cannot hang
    task automatic pollClear(input int bitPos);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        d = 32'hffffffff;
        while (d[bitPos] !== 1'b0 && n < 400) begin
            axiRead(nv_ctrl_pkg::OFF_CONTROL, d, r);
            n++;
        end
    endtask : pollClear

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testReset;
        logic [31:0] d;
        logic [1:0]  r;
        rdChk("location reset", nv_ctrl_pkg::OFF_LOCATION, 32'h0);
        rdChk("byte reset", nv_ctrl_pkg::OFF_BYTE, {24'h0, nv_ctrl_pkg::RST_BYTE});
        rdChk("bank reset", nv_ctrl_pkg::OFF_BANK, 32'h0);
        rdChk("irq reset", nv_ctrl_pkg::OFF_IRQ, 32'h0);
        axiRead(nv_ctrl_pkg::OFF_CONTROL, d, r);
        `CHK("control resp bank0", nv_ctrl_pkg::RESP_SLVERR, r)
        `CHK("control data bank0", 32'h0, d)
        axiWrite(nv_ctrl_pkg::OFF_CONTROL, 32'h0000000c, r);
        `CHK("control write bank0", nv_ctrl_pkg::RESP_SLVERR, r)
        axiRead(8'h14, d, r);
        `CHK("unmapped resp", nv_ctrl_pkg::RESP_SLVERR, r)
        wrOk(nv_ctrl_pkg::OFF_BANK, 32'h1);
        rdChk("control reset", nv_ctrl_pkg::OFF_CONTROL, {28'h0, nv_ctrl_pkg::RST_CTL});
    endtask : testReset

    task automatic testWriteGate;
        wrOk(nv_ctrl_pkg::OFF_LOCATION, 32'h5);
        wrOk(nv_ctrl_pkg::OFF_BYTE, 32'h5a);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h4);
        rdChk("trigger without permit", nv_ctrl_pkg::OFF_CONTROL, 32'h0);
        repeat (20) @(posedge core_clk);
        rdChk("no flags without write", nv_ctrl_pkg::OFF_IRQ, 32'h0);
    endtask : testWriteGate

    task automatic testWriteCycle;
        int el;
        int t0;
        // location and byte loaded earlier, then permit, then trigger
        // permit and trigger back to back; global enable kept low
        // no sleep modelled; triggers never set together
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h8);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'hc);
        t0 = cycleCount;
        rdChk("write busy", nv_ctrl_pkg::OFF_CONTROL, 32'hc);
        // completion found by polling the write trigger
        pollClear(nv_ctrl_pkg::CTL_WR_TRIG);
        el = cycleCount - t0;
        `CHK("write time", 1'b1, logic'(el >= nv_ctrl_pkg::WR_CYCLES - 8 && el <= nv_ctrl_pkg::WR_CYCLES + 24))
        rdChk("write trigger cleared", nv_ctrl_pkg::OFF_CONTROL, 32'h8);
        rdChk("flags after write", nv_ctrl_pkg::OFF_IRQ, 32'h18);
        `CHK("vector masked", 1'b0, irqVector)
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h0);
    endtask : testWriteCycle

    task automatic testReadCycle;
        wrOk(nv_ctrl_pkg::OFF_BYTE, 32'h0);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h1);
        rdChk("read trig without permit", nv_ctrl_pkg::OFF_CONTROL, 32'h0);
        rdChk("byte untouched", nv_ctrl_pkg::OFF_BYTE, 32'h0);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h2);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h3);
        pollClear(nv_ctrl_pkg::CTL_RD_TRIG);
        rdChk("read byte", nv_ctrl_pkg::OFF_BYTE, 32'h5a);
        repeat (30) @(posedge core_clk);
        wrOk(nv_ctrl_pkg::OFF_LOCATION, 32'hff);
        rdChk("location width", nv_ctrl_pkg::OFF_LOCATION, 32'h3f);
        rdChk("byte kept", nv_ctrl_pkg::OFF_BYTE, 32'h5a);
        wrOk(nv_ctrl_pkg::OFF_CONTROL, 32'h0);
    endtask : testReadCycle

    task automatic testIrq;
        for (int en = 0; en < 8; en++) begin
            wrOk(nv_ctrl_pkg::OFF_IRQ, 32'h18 | 32'(en));
            repeat (3) @(posedge core_clk);
            `CHK("vector per enables", logic'(en == 7), irqVector)
        end
        stackFull <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("vector stack full", 1'b0, irqVector)
        stackFull <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("vector stack free", 1'b1, irqVector)
        irqService <= 1'b1;
        @(posedge core_clk);
        irqService <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdChk("irq after service", nv_ctrl_pkg::OFF_IRQ, 32'h0f);
        `CHK("vector after service", 1'b0, irqVector)
        wrOk(nv_ctrl_pkg::OFF_IRQ, 32'h07);
        rdChk("memory flag cleared", nv_ctrl_pkg::OFF_IRQ, 32'h07);
    endtask : testIrq

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Cuts a hang short; limit well above the few hundred cycles needed
    always @(posedge core_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == TIMEOUT) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        testReset();
        testWriteGate();
        testWriteCycle();
        testReadCycle();
        testIrq();
        report_and_stop();
    end
endmodule : nv_byte_ctrl_tb_top
